//--- shared/aipl_pkg.sv
// Package for the auto-increment page loader: field widths, frame codes, timing.
// Assumes a 50 MHz reference clock sampling the bus clock and pins.
package aipl_pkg;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned ADDR_NIBS = 7;
  localparam int unsigned ADDR_W = 28;
  localparam int unsigned PAGE_LSB = 7;
  localparam int unsigned PAGE_MSB = 20;
  localparam int unsigned PAGE_W = PAGE_MSB - PAGE_LSB + 1;
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CNT_W = 8;
  localparam logic [3:0] START_FW_WRITE = 4'he;
  localparam logic [2:0] ADDR_LAST = 3'h6;
  // Program time per byte, worst case
  localparam int unsigned BYTE_PROG_NS = 10000;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned BYTE_PROG_CYC = (BYTE_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FIFO_DEPTH = 8;
  typedef enum logic [6:0] {
    AIPL_IDLE  = 7'h01,
    AIPL_SEL   = 7'h02,
    AIPL_ADDR  = 7'h04,
    AIPL_SIZE  = 7'h08,
    AIPL_DATA  = 7'h10,
    AIPL_DRAIN = 7'h20,
    AIPL_SKIP  = 7'h40
  } aipl_state_e;
endpackage : aipl_pkg

//--- rtl/aipl_fifo.sv
// Byte FIFO between the bus loader and the program engine.
// Assumes one clock; push when in_valid and in_ready, pop when out_valid and out_ready.
`timescale 1ns/1ns
module aipl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_q <= '0;
        rd_q <= '0;
        cnt_q <= '0;
      end else begin
        if (push) begin
          wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
          rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule : aipl_fifo

//--- rtl/aipl_loader.sv
// Device-side loader for high-voltage auto-increment page programming.
// Assumes bus clock, frame, data nibbles, strobe and straps come from outside ref_clk.
// Function
// R1: Strobe low and buffer full: hold ready/busy low, take no nibbles.
// R2: After byte 128 with strobe low, ready/busy high means new operation only.
// R3: Strobe high: ready/busy low while programming, high when idle.
// R4: Programmer leaves the mode only with strobe high and ready/busy high.
// R5: In the mode, every block is treated as write-unlocked.
// R6: Programmer keeps supervoltage until ready/busy high with strobe high.
// R7: Start nibble 1110 with frame low; last one before frame rises counts.
// R8: Chip-select nibble must match strap pins to join the frame.
// R9: Seven address nibbles, most significant first, assembled in order.
// R10: Only address bits 20 to 7 select the page.
// R11: Size nibble is accepted and ignored.
// R12: Data nibbles low first, bytes 0 to 127, while ready high and strobe low.
// R13: Host stops clock while ready/busy is low, then resumes.
// R14: Mode entered only while protect pin is at supervoltage.
// R15: Keep accepting data while strobe low and ready high, up to byte 128.
// R16: Strobe rising early: program received bytes, then end command.
// R17: A byte with only one nibble is discarded.
// R18: On chip-select mismatch, leave buffer and ready/busy untouched.
`timescale 1ns/1ns
module aipl_loader #(
  parameter int unsigned PAGE_BYTES = aipl_pkg::PAGE_BYTES,
  parameter int unsigned FIFO_DEPTH = aipl_pkg::FIFO_DEPTH,
  parameter int unsigned PROG_CYC = aipl_pkg::BYTE_PROG_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic bus_clk,
  input wire logic frame_n,
  input wire logic [3:0] bus_data,
  input wire logic load_strobe,
  input wire logic supervoltage_level,
  input wire logic [3:0] strap_id_pins,
  output logic ready_busy_out,
  output logic auto_increment_mode,
  output logic write_unlock_all,
  output logic prog_valid,
  output logic [aipl_pkg::PAGE_W-1:0] prog_page,
  output logic [6:0] prog_offset,
  output logic [aipl_pkg::BYTE_W-1:0] prog_data
);
  ////////////////////////////////////////////////////////////////////////////
  // Three-stage input sampling; change counts when stages two and three agree
  logic [2:0] clk_s_q, frm_s_q, ld_s_q, hv_s_q;
  logic [3:0] d1_q, d2_q, d3_q;
  logic clk_f_q, frm_f_q, ld_f_q, hv_f_q;
  logic [3:0] dat_f_q;
  logic clk_prev_q;
  logic [3:0] id_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_s_q <= 3'h0;
      frm_s_q <= 3'h7;
      ld_s_q <= 3'h7;
      hv_s_q <= 3'h0;
      d1_q <= 4'h0;
      d2_q <= 4'h0;
      d3_q <= 4'h0;
      clk_f_q <= 1'b0;
      frm_f_q <= 1'b1;
      ld_f_q <= 1'b1;
      hv_f_q <= 1'b0;
      dat_f_q <= 4'h0;
      clk_prev_q <= 1'b0;
      id_q <= 4'h0;
    end else if (clk_en) begin
      clk_s_q <= {clk_s_q[1:0], bus_clk};
      frm_s_q <= {frm_s_q[1:0], frame_n};
      ld_s_q <= {ld_s_q[1:0], load_strobe};
      hv_s_q <= {hv_s_q[1:0], supervoltage_level};
      d1_q <= bus_data;
      d2_q <= d1_q;
      d3_q <= d2_q;
      if (clk_s_q[1] == clk_s_q[2]) clk_f_q <= clk_s_q[2];
      if (frm_s_q[1] == frm_s_q[2]) frm_f_q <= frm_s_q[2];
      if (ld_s_q[1] == ld_s_q[2]) ld_f_q <= ld_s_q[2];
      if (hv_s_q[1] == hv_s_q[2]) hv_f_q <= hv_s_q[2];
      if (d2_q == d3_q) dat_f_q <= d3_q;
      clk_prev_q <= clk_f_q;
      id_q <= strap_id_pins;
    end
  end

  logic bus_rise;
  assign bus_rise = clk_f_q && !clk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoding
  aipl_pkg::aipl_state_e st_q;
  logic [2:0] anib_q;
  logic [aipl_pkg::ADDR_W-1:0] addr_q;
  logic [aipl_pkg::CNT_W-1:0] bytes_q;
  logic half_q;
  logic [3:0] low_nib_q;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [aipl_pkg::BYTE_W-1:0] fifo_out_data;
  logic push_byte;
  logic prog_busy_q;
  logic take_nib;
  logic page_full;

  assign page_full = (bytes_q == aipl_pkg::CNT_W'(PAGE_BYTES));
  // R1 R12 R15 nibble gating
  assign take_nib = bus_rise && !ld_f_q && fifo_in_ready && !page_full;
  assign push_byte = (st_q == aipl_pkg::AIPL_DATA) && take_nib && half_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= aipl_pkg::AIPL_IDLE;
      anib_q <= 3'h0;
      addr_q <= '0;
      bytes_q <= '0;
      half_q <= 1'b0;
      low_nib_q <= 4'h0;
    end else if (clk_en) begin
      case (st_q)
        aipl_pkg::AIPL_IDLE: begin
          // R7 R14 last start nibble wins
          if (bus_rise && !frm_f_q && hv_f_q && dat_f_q == aipl_pkg::START_FW_WRITE) begin
            st_q <= aipl_pkg::AIPL_SEL;
          end
        end
        aipl_pkg::AIPL_SEL: begin
          if (bus_rise && !frm_f_q) begin
            if (dat_f_q != aipl_pkg::START_FW_WRITE) st_q <= aipl_pkg::AIPL_IDLE;
          end else if (bus_rise) begin
            // R8 R18 chip-select match
            st_q <= (dat_f_q == id_q) ? aipl_pkg::AIPL_ADDR : aipl_pkg::AIPL_SKIP;
            anib_q <= 3'h0;
          end
        end
        aipl_pkg::AIPL_ADDR: begin
          if (bus_rise) begin
            // R9 most significant nibble first
            addr_q <= {addr_q[aipl_pkg::ADDR_W-5:0], dat_f_q};
            anib_q <= anib_q + 3'h1;
            if (anib_q == aipl_pkg::ADDR_LAST) st_q <= aipl_pkg::AIPL_SIZE;
          end
        end
        aipl_pkg::AIPL_SIZE: begin
          // R11 size nibble discarded
          if (bus_rise) begin
            st_q <= aipl_pkg::AIPL_DATA;
            bytes_q <= '0;
            half_q <= 1'b0;
          end
        end
        aipl_pkg::AIPL_DATA: begin
          if (ld_f_q) begin
            // R16 R17 early end, half byte dropped
            half_q <= 1'b0;
            st_q <= aipl_pkg::AIPL_DRAIN;
          end else if (take_nib) begin
            half_q <= !half_q;
            if (!half_q) low_nib_q <= dat_f_q;
            if (half_q) bytes_q <= bytes_q + 1'b1;
          end
          if (!hv_f_q) st_q <= aipl_pkg::AIPL_IDLE;
        end
        aipl_pkg::AIPL_DRAIN: begin
          if (!fifo_out_valid && !prog_busy_q) st_q <= aipl_pkg::AIPL_IDLE;
        end
        aipl_pkg::AIPL_SKIP: begin
          // R18 mismatched frame ends when the frame strobe falls again
          if (!frm_f_q) st_q <= aipl_pkg::AIPL_IDLE;
        end
        default: st_q <= aipl_pkg::AIPL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte buffer; full buffer stalls nibble intake
  aipl_fifo #(
    .WIDTH(aipl_pkg::BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .flush(st_q == aipl_pkg::AIPL_IDLE),
    .in_valid(push_byte),
    .in_ready(fifo_in_ready),
    .in_data({dat_f_q, low_nib_q}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Program engine: one byte per timed slot
  logic [$clog2(PROG_CYC+1)-1:0] tmr_q;
  logic [6:0] off_q;
  assign fifo_pop = fifo_out_valid && !prog_busy_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_busy_q <= 1'b0;
      tmr_q <= '0;
      off_q <= 7'h0;
      prog_valid <= 1'b0;
      prog_page <= '0;
      prog_offset <= 7'h0;
      prog_data <= 8'h0;
    end else if (clk_en) begin
      prog_valid <= 1'b0;
      if (st_q == aipl_pkg::AIPL_SIZE) off_q <= 7'h0;
      if (fifo_pop) begin
        prog_busy_q <= 1'b1;
        tmr_q <= ($clog2(PROG_CYC+1))'(PROG_CYC);
        prog_valid <= 1'b1;
        // R10 page bits only
        prog_page <= addr_q[aipl_pkg::PAGE_MSB:aipl_pkg::PAGE_LSB];
        prog_offset <= off_q;
        prog_data <= fifo_out_data;
        off_q <= off_q + 7'h1;
      end else if (prog_busy_q) begin
        tmr_q <= tmr_q - 1'b1;
        if (tmr_q == 1) prog_busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs
  logic in_op;
  assign in_op = (st_q == aipl_pkg::AIPL_DATA) || (st_q == aipl_pkg::AIPL_DRAIN);
  // R14 R5 mode follows supervoltage
  assign auto_increment_mode = hv_f_q;
  assign write_unlock_all = hv_f_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_busy_out <= 1'b1;
    end else if (clk_en) begin
      if (st_q == aipl_pkg::AIPL_DATA && !ld_f_q) begin
        // R1 R2 R15 busy when full or page done and draining
        ready_busy_out <= fifo_in_ready && !(page_full && (fifo_out_valid || prog_busy_q));
      end else if (in_op) begin
        // R3 busy until programming ends
        ready_busy_out <= !(fifo_out_valid || prog_busy_q);
      end else begin
        ready_busy_out <= 1'b1;
      end
    end
  end
endmodule : aipl_loader

//--- tb/aipl_loader_chk.sv
// Checker for the page loader output ports.
// Assumes a bind onto aipl_loader and one reference clock domain.
`timescale 1ns/1ns
module aipl_loader_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic supervoltage_level,
  input wire logic load_strobe,
  input wire logic ready_busy_out,
  input wire logic auto_increment_mode,
  input wire logic write_unlock_all,
  input wire logic prog_valid,
  input wire logic [aipl_pkg::PAGE_W-1:0] prog_page,
  input wire logic [6:0] prog_offset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [6:0] last_q;
  logic [aipl_pkg::PAGE_W-1:0] page_q;
  // Previous byte, so order holds across pauses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 7'h7f;
      page_q <= '0;
    end else if (prog_valid) begin
      last_q <= prog_offset;
      page_q <= prog_page;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_unlock; write_unlock_all == auto_increment_mode; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock differs from mode");
  property p_no_sv; !supervoltage_level [*8] |-> !auto_increment_mode; endproperty
  a_no_sv: assert property (p_no_sv) else $error("mode without supervoltage");
  property p_prog_mode; prog_valid |-> auto_increment_mode; endproperty
  a_prog_mode: assert property (p_prog_mode) else $error("byte outside mode");
  property p_order;
    prog_valid |-> prog_offset == 7'h00 || prog_offset == last_q + 7'h01;
  endproperty
  a_order: assert property (p_order) else $error("byte offset out of order");
  property p_page; prog_valid && prog_offset != 7'h00 |-> prog_page == page_q; endproperty
  a_page: assert property (p_page) else $error("page changed within page");
  property p_busy; load_strobe [*8] ##0 prog_valid |-> !ready_busy_out; endproperty
  a_busy: assert property (p_busy) else $error("ready while programming");
  property p_last; prog_valid && prog_offset == 7'h7f |=> !ready_busy_out; endproperty
  a_last: assert property (p_last) else $error("ready right after last byte");
  property p_pulse; prog_valid |=> !prog_valid [*3]; endproperty
  a_pulse: assert property (p_pulse) else $error("program pulses too close");
  property p_idle; !auto_increment_mode [*8] |-> ready_busy_out; endproperty
  a_idle: assert property (p_idle) else $error("busy outside mode");
endmodule : aipl_loader_chk

bind aipl_loader aipl_loader_chk u_aipl_loader_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .supervoltage_level(supervoltage_level), .load_strobe(load_strobe),
  .ready_busy_out(ready_busy_out), .auto_increment_mode(auto_increment_mode),
  .write_unlock_all(write_unlock_all), .prog_valid(prog_valid), .prog_page(prog_page),
  .prog_offset(prog_offset));

//--- tb/aipl_host_model.sv
// Host model: drives one auto-increment frame on the nibble bus.
// Assumes the loader samples these pins with its own clock.
`timescale 1ns/1ns
module aipl_host_model (
  output logic bus_clk,
  output logic frame_n,
  output logic load_strobe,
  output logic [3:0] bus_data,
  input wire logic ready_busy_out
);
  initial begin
    bus_clk = 1'b0;
    frame_n = 1'b1;
    load_strobe = 1'b1;
    bus_data = 4'h0;
  end
  // Clock stands still between nibbles and frames
  // Non-blocking, so edges that land on a sampling edge do not race it
  task automatic send(input logic [3:0] n);
    bus_data <= n;
    #80 bus_clk <= 1'b1;
    #80 bus_clk <= 1'b0;
  endtask : send
  task automatic run(input logic [3:0] sel, input logic [27:0] a, input int nb, input bit lone);
    logic [7:0] d;
    frame_n <= 1'b0;
    send(4'he);
    frame_n <= 1'b1;
    send(sel);
    for (int i = 6; i >= 0; i--) send(a[i*4+:4]);
    // Strobe low before data state, which ends the load on a high strobe
    load_strobe <= 1'b0;
    send(4'h3);
    for (int i = 0; i < 2 * nb + int'(lone); i++) begin
      d = 8'(i / 2 * 37 + 5);
      #120 wait (ready_busy_out === 1'b1);
      send(i[0] ? d[7:4] : d[3:0]);
    end
    #80 load_strobe <= 1'b1;
    bus_data <= ~bus_data;
  endtask : run
endmodule : aipl_host_model

//--- tb/aipl_loader_tb_top.sv
// Bench for the page loader with a host model on the nibble bus.
// Assumes the checker is bound from its own file; slow program time fills the buffer.
`timescale 1ns/1ns
module aipl_loader_tb_top;
  localparam logic [27:0] ADDR = 28'hd5a3c9e;
  logic ref_clk, rst_n, clk_en, supervoltage_level, bus_clk, frame_n, load_strobe;
  logic ready_busy_out, auto_increment_mode, write_unlock_all, prog_valid;
  logic [3:0] bus_data, strap_id_pins;
  logic [aipl_pkg::PAGE_W-1:0] prog_page;
  logic [6:0] prog_offset;
  logic [7:0] prog_data;
  logic [28:0] got[$];
  int failures = 0;
  int checks_done = 0;
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  aipl_loader #(.PROG_CYC(40)) u_aipl_loader (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .bus_clk(bus_clk), .frame_n(frame_n), .bus_data(bus_data), .load_strobe(load_strobe),
    .supervoltage_level(supervoltage_level), .strap_id_pins(strap_id_pins),
    .ready_busy_out(ready_busy_out), .auto_increment_mode(auto_increment_mode),
    .write_unlock_all(write_unlock_all), .prog_valid(prog_valid), .prog_page(prog_page),
    .prog_offset(prog_offset), .prog_data(prog_data));
  aipl_host_model u_aipl_host_model (.bus_clk(bus_clk), .frame_n(frame_n),
    .load_strobe(load_strobe), .bus_data(bus_data), .ready_busy_out(ready_busy_out));
  always @(posedge ref_clk) begin
    if (prog_valid === 1'b1) got.push_back({prog_page, prog_offset, prog_data});
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] dat(input int b);
    return 8'(b * 37 + 5);
  endfunction : dat
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // Sends a frame, waits for idle, then compares every programmed byte
  task automatic run_frame(input logic [3:0] sel, input int nb, input bit lone, input int expn);
    int i;
    got.delete();
    u_aipl_host_model.run(sel, ADDR, nb, lone);
    repeat (12) @(posedge ref_clk);
    i = 0;
    while (ready_busy_out !== 1'b1 && i < 20000) begin
      @(posedge ref_clk);
      i++;
    end
    cmp("ready", 32'h1, {31'h0, ready_busy_out});
    cmp("count", 32'(expn), 32'(got.size()));
    for (i = 0; i < got.size() && i < expn; i++)
      cmp("byte", {3'h0, ADDR[20:7], 7'(i), dat(i)}, {3'h0, got[i]});
  endtask : run_frame
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_no_sv();
    run_frame(4'h9, 2, 1'b0, 0);
    cmp("mode", 32'h0, {31'h0, auto_increment_mode});
  endtask : t_no_sv
  task automatic t_mismatch();
    supervoltage_level <= 1'b1;
    repeat (10) @(posedge ref_clk);
    run_frame(4'h6, 3, 1'b0, 0);
  endtask : t_mismatch
  task automatic t_full_page();
    run_frame(4'h9, 128, 1'b0, 128);
    cmp("unlock", 32'h1, {31'h0, write_unlock_all});
  endtask : t_full_page
  task automatic t_partial();
    run_frame(4'h9, 5, 1'b1, 5);
    // supervoltage dropped only after ready with strobe high
    supervoltage_level <= 1'b0;
    repeat (10) @(posedge ref_clk);
    cmp("mode", 32'h0, {31'h0, auto_increment_mode});
  endtask : t_partial
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    supervoltage_level = 1'b0;
    strap_id_pins = 4'h9;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
    t_no_sv();
    t_mismatch();
    t_full_page();
    t_partial();
    test_done();
  end
  initial begin
    #1000000;
    failures++;
    test_done();
  end
endmodule : aipl_loader_tb_top
